/* File: hw/scg_pkg.sv */
// Package of constants and types for the system clock generation block.
package scg_pkg;
   // Register byte offsets.
   localparam logic [11:0] OFS_SYSTEM_CONTROL_REG0 = 12'h000;
   localparam logic [11:0] OFS_PLL_CONTROL_REG0    = 12'h004;
   localparam logic [11:0] OFS_PRESCALE_CONTROL    = 12'h008;
   localparam logic [11:0] OFS_CLOCK_STATUS        = 12'h00c;
   // Source select codes.
   localparam logic [1:0]  SEL_WAKEUP = 2'h0;
   localparam logic [1:0]  SEL_PLLPRE = 2'h2;
   localparam logic [1:0]  SEL_DIRECT = 2'h3;
   // Field positions in the PLL control register.
   localparam int          POS_VCO_BYPASS  = 0;
   localparam int          POS_PLL_REF_SEL = 1;
   localparam int          POS_BAND        = 2;
   localparam int          POS_PLL_INPUT_DIVIDER_FIELD        = 4;
   localparam int          POS_PLL_MULTIPLIER_FIELD        = 8;
   localparam int          POS_PLL_OUTPUT_DIVIDER_FIELD       = 16;
   // Field positions in the prescale control register.
   localparam int          POS_PRESCALER_DIVIDER_FIELD       = 0;
   localparam int          POS_PRE_SRC     = 16;
   // Values after reset.
   localparam logic [1:0]  RST_SOURCE_SELECT = 2'h0;
   localparam logic        RST_VCO_BYPASS    = 1'h1;
   localparam logic [9:0]  RST_PRESCALER_DIVIDER_FIELD         = 10'h000;
   localparam logic [3:0]  RST_PLL_INPUT_DIVIDER_FIELD          = 4'h0;
   localparam logic [7:0]  RST_PLL_MULTIPLIER_FIELD          = 8'h03;
   localparam logic [6:0]  RST_PLL_OUTPUT_DIVIDER_FIELD         = 7'h01;
   localparam logic [1:0]  RST_BAND          = 2'h0;
   // VCO half-period limits in clk cycles per band.
   localparam logic [1:0]  BAND_LOW       = 2'h0;
   localparam logic [1:0]  BAND_HIGH      = 2'h1;
   localparam logic [7:0]  BAND_LOW_MIN   = 8'h04;
   localparam logic [7:0]  BAND_LOW_MAX   = 8'h28;
   localparam logic [7:0]  BAND_HIGH_MIN  = 8'h02;
   localparam logic [7:0]  BAND_HIGH_MAX  = 8'h14;
   // Clock switch sequencer states.
   typedef enum logic [2:0] {
      SCG_RUN   = 3'h1,
      SCG_DRAIN = 3'h2,
      SCG_PARK  = 3'h4
   } scg_state_t;
endpackage : scg_pkg

/* File: hw/scg_div_if.sv */
// Interface between the clock generator and each of its integer dividers.
`timescale 1ns/1ps
`default_nettype none
interface scg_div_if;
   logic        tick;
   logic        level;
   logic [10:0] ratio;
   logic        out;
   modport drv (output tick, output level, output ratio, input out);
   modport div (input tick, input level, input ratio, output out);
endinterface : scg_div_if
`default_nettype wire

/* File: hw/scg_div.sv */
// Glitch-free integer clock divider with ratio taken at period boundary.
`timescale 1ns/1ps
`default_nettype none
module scg_div
   import scg_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // Divider port
   scg_div_if.div    d
);
   logic [10:0] cnt;
   logic [10:0] ratio_act;
   logic        div_q;

   // A new ratio is taken only at the wrap, so no period is ever cut short.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt       <= 11'h000;
         ratio_act <= 11'h001;
         div_q     <= 1'b0;
      end else if (d.tick) begin
         if (cnt >= ratio_act - 11'h001) begin
            cnt       <= 11'h000;
            ratio_act <= d.ratio;
            div_q     <= (d.ratio > 11'h001);
         end else begin
            cnt   <= cnt + 11'h001;
            div_q <= (cnt + 11'h001) < (ratio_act >> 1);
         end
      end
   end

   // Ratio one passes the source level straight through.
   assign d.out = (ratio_act == 11'h001) ? d.level : div_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_wrap;
      d.tick && (cnt >= ratio_act - 11'h001) |=> cnt == 11'h000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("divider did not wrap at its ratio");

   property p_rise_at_wrap;
      $rose(div_q) |-> (cnt == 11'h000) && (ratio_act > 11'h001);
   endproperty
   a_rise_at_wrap: assert property (p_rise_at_wrap) else $error("divided clock rose off the wrap");

   property p_cnt_range;
      cnt < ratio_act || ratio_act == 11'h000;
   endproperty
   a_cnt_range: assert property (p_cnt_range) else $error("divider count beyond ratio");
endmodule : scg_div
`default_nettype wire

/* File: hw/scg_top.sv */
// System clock generator: source select, prescaler, digital PLL, APB registers.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module scg_top
   import scg_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Clock sources, sampled as levels
   input  wire logic        direct_clock_input,
   input  wire logic        crystal_input,
   input  wire logic        internal_clock_input,
   input  wire logic        wakeup_clock_input,
   // Generated clock
   output var  logic        sys_clk
);
   ////////////////////////////////////////////////////////////////////////////
   logic [1:0]  clock_source_select;
   logic        vco_bypass;
   logic        pll_ref_select;
   logic [1:0]  vco_band_select;
   logic [3:0]  pll_input_divider_field;
   logic [7:0]  pll_multiplier_field;
   logic [6:0]  pll_output_divider_field;
   logic [9:0]  prescaler_divider_field;
   logic        prescale_src_select;
   logic [1:0]  act_sel;
   logic        act_bypass;
   logic        act_pre_src;
   logic        act_ref;
   scg_state_t  state;
   scg_state_t  next_state;
   logic        mux;
   logic        next_sys;
   logic        pll_on;
   logic        pll_locked;
   logic        xtal_q;
   logic        int_q;
   logic        cfg_change;
   logic        apb_go;

   scg_div_if pre ();
   scg_div_if k2 ();

   ////////////////////////////////////////////////////////////////////////////
   // APB register file with one wait state per access.
   assign apb_go = psel && penable && pready;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         clock_source_select      <= RST_SOURCE_SELECT;
         vco_bypass               <= RST_VCO_BYPASS;
         pll_ref_select           <= 1'b0;
         vco_band_select          <= RST_BAND;
         pll_input_divider_field  <= RST_PLL_INPUT_DIVIDER_FIELD;
         pll_multiplier_field     <= RST_PLL_MULTIPLIER_FIELD;
         pll_output_divider_field <= RST_PLL_OUTPUT_DIVIDER_FIELD;
         prescaler_divider_field  <= RST_PRESCALER_DIVIDER_FIELD;
         prescale_src_select      <= 1'b0;
      end else if (apb_go && pwrite) begin
         case (paddr)
            OFS_SYSTEM_CONTROL_REG0: begin
               clock_source_select <= pwdata[1:0];
            end
            OFS_PLL_CONTROL_REG0: begin
               vco_bypass               <= pwdata[POS_VCO_BYPASS];
               pll_ref_select           <= pwdata[POS_PLL_REF_SEL];
               vco_band_select          <= pwdata[POS_BAND +: 2];
               pll_input_divider_field  <= pwdata[POS_PLL_INPUT_DIVIDER_FIELD +: 4];
               pll_multiplier_field     <= pwdata[POS_PLL_MULTIPLIER_FIELD +: 8];
               pll_output_divider_field <= pwdata[POS_PLL_OUTPUT_DIVIDER_FIELD +: 7];
            end
            OFS_PRESCALE_CONTROL: begin
               prescaler_divider_field <= pwdata[POS_PRESCALER_DIVIDER_FIELD +: 10];
               prescale_src_select     <= pwdata[POS_PRE_SRC];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         case (paddr)
            OFS_SYSTEM_CONTROL_REG0: prdata[1:0] <= clock_source_select;
            OFS_PLL_CONTROL_REG0: begin
               prdata[POS_VCO_BYPASS]     <= vco_bypass;
               prdata[POS_PLL_REF_SEL]    <= pll_ref_select;
               prdata[POS_BAND +: 2]      <= vco_band_select;
               prdata[POS_PLL_INPUT_DIVIDER_FIELD +: 4]      <= pll_input_divider_field;
               prdata[POS_PLL_MULTIPLIER_FIELD +: 8]      <= pll_multiplier_field;
               prdata[POS_PLL_OUTPUT_DIVIDER_FIELD +: 7]     <= pll_output_divider_field;
            end
            OFS_PRESCALE_CONTROL: begin
               prdata[POS_PRESCALER_DIVIDER_FIELD +: 10] <= prescaler_divider_field;
               prdata[POS_PRE_SRC]     <= prescale_src_select;
            end
            OFS_CLOCK_STATUS: begin
               prdata[5:0] <= {sys_clk, pll_locked, (state != SCG_RUN), act_bypass, act_sel};
            end
            default: pslverr <= 1'b1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source edge detection.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         xtal_q <= 1'b0;
         int_q  <= 1'b0;
      end else begin
         xtal_q <= crystal_input;
         int_q  <= internal_clock_input;
      end
   end

   // Prescaler path.
   assign pre.level = act_pre_src ? internal_clock_input : crystal_input;
   assign pre.tick  = act_pre_src ? (internal_clock_input && !int_q)
                                  : (crystal_input && !xtal_q);
   assign pre.ratio = {1'b0, prescaler_divider_field} + 11'h001;

   scg_div u_pre_div (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (pre.div)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Digital PLL: reference divided by P, a counted VCO steered by a
   // frequency loop toward N VCO edges per divided reference period.
   logic        ref_rise;
   logic        ref_tick;
   logic [3:0]  p_cnt;
   logic [7:0]  vco_cnt;
   logic [7:0]  vco_half;
   logic        vco_clk;
   logic        vco_rise;
   logic [8:0]  vco_seen;
   logic [8:0]  n_ratio;
   logic [7:0]  band_min;
   logic [7:0]  band_max;

   assign pll_on   = (act_sel == SEL_PLLPRE) && !act_bypass;
   assign ref_rise = act_ref ? (internal_clock_input && !int_q)
                             : (crystal_input && !xtal_q);
   assign ref_tick = pll_on && ref_rise && (p_cnt >= pll_input_divider_field);
   assign n_ratio  = {1'b0, pll_multiplier_field} + 9'h001;
   assign vco_rise = pll_on && !vco_clk && (vco_cnt >= vco_half - 8'h01);
   assign band_min = (vco_band_select == BAND_HIGH) ? BAND_HIGH_MIN : BAND_LOW_MIN;
   assign band_max = (vco_band_select == BAND_HIGH) ? BAND_HIGH_MAX : BAND_LOW_MAX;

   always_ff @(posedge clk) begin
      if (!rst_b || !pll_on) begin
         p_cnt <= 4'h0;
      end else if (ref_rise) begin
         p_cnt <= ref_tick ? 4'h0 : p_cnt + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || !pll_on) begin
         vco_cnt <= 8'h00;
         vco_clk <= 1'b0;
      end else if (vco_cnt >= vco_half - 8'h01) begin
         vco_cnt <= 8'h00;
         vco_clk <= !vco_clk;
      end else begin
         vco_cnt <= vco_cnt + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || !pll_on) begin
         vco_seen <= 9'h000;
      end else if (ref_tick) begin
         vco_seen <= {8'h00, vco_rise};
      end else if (vco_rise && vco_seen != 9'h1ff) begin
         vco_seen <= vco_seen + 9'h001;
      end
   end

   // The loop moves the half period one cycle per divided reference period, so the
   // frequency slews instead of jumping; lock takes longer as the trade.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         vco_half   <= BAND_LOW_MAX;
         pll_locked <= 1'b0;
      end else if (!pll_on) begin
         vco_half   <= band_max;
         pll_locked <= 1'b0;
      end else if (ref_tick) begin
         pll_locked <= (vco_seen == n_ratio);
         if (vco_half > band_max) begin
            vco_half <= vco_half - 8'h01;
         end else if (vco_half < band_min) begin
            vco_half <= vco_half + 8'h01;
         end else if (vco_seen < n_ratio && vco_half > band_min) begin
            vco_half <= vco_half - 8'h01;
         end else if (vco_seen > n_ratio && vco_half < band_max) begin
            vco_half <= vco_half + 8'h01;
         end
      end
   end

   assign k2.tick  = vco_rise;
   assign k2.level = vco_clk;
   assign k2.ratio = {4'h0, pll_output_divider_field} + 11'h001;

   scg_div u_k2_div (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (k2.div)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Source multiplexer and glitch-free switch sequencer.
   always_comb begin
      case (act_sel)
         SEL_DIRECT: mux = direct_clock_input;
         SEL_PLLPRE: mux = act_bypass ? pre.out : k2.out;
         SEL_WAKEUP: mux = wakeup_clock_input;
         default:    mux = 1'b0;
      endcase
   end

   assign cfg_change = (clock_source_select != act_sel) || (vco_bypass != act_bypass) ||
                       (prescale_src_select != act_pre_src) || (pll_ref_select != act_ref);

   // The old source is let finish its high phase and the new one is joined
   // only while low, so no short pulse can reach the output.
   always_comb begin
      next_state = state;
      case (state)
         SCG_RUN:   if (cfg_change) next_state = SCG_DRAIN;
         SCG_DRAIN: if (!mux) next_state = SCG_PARK;
         SCG_PARK:  if (!mux) next_state = SCG_RUN;
         default:   next_state = SCG_RUN;
      endcase
   end

   assign next_sys = (state == SCG_PARK) ? 1'b0 : mux;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state   <= SCG_RUN;
         sys_clk <= 1'b0;
      end else begin
         state   <= next_state;
         sys_clk <= next_sys;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         act_sel     <= RST_SOURCE_SELECT;
         act_bypass  <= RST_VCO_BYPASS;
         act_pre_src <= 1'b0;
         act_ref     <= 1'b0;
      end else if (state == SCG_DRAIN && !mux) begin
         act_sel     <= clock_source_select;
         act_bypass  <= vco_bypass;
         act_pre_src <= prescale_src_select;
         act_ref     <= pll_ref_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_drain_done;
      state == SCG_DRAIN && !mux;
   endsequence
   sequence s_parked;
      state == SCG_PARK && !sys_clk;
   endsequence

   property p_switch;
      s_drain_done |=> s_parked;
   endproperty
   a_switch: assert property (p_switch) else $error("switch did not park the clock low");

   property p_park_low;
      state == SCG_PARK |=> (state == SCG_PARK) ? !sys_clk : ($past(mux) == 1'b0);
   endproperty
   a_park_low: assert property (p_park_low) else $error("clock high while parked");

   property p_direct;
      state == SCG_RUN && act_sel == SEL_DIRECT |=> sys_clk == $past(direct_clock_input);
   endproperty
   a_direct: assert property (p_direct) else $error("direct mode not following input");

   property p_wakeup;
      state == SCG_RUN && act_sel == SEL_WAKEUP |=> sys_clk == $past(wakeup_clock_input);
   endproperty
   a_wakeup: assert property (p_wakeup) else $error("wakeup mode not following input");

   property p_pll_idle;
      !pll_on |=> !vco_clk && vco_cnt == 8'h00;
   endproperty
   a_pll_idle: assert property (p_pll_idle) else $error("VCO running outside PLL mode");

   property p_slew;
      pll_on && $past(pll_on) && vco_half != $past(vco_half) |->
         (vco_half == $past(vco_half) + 8'h01) || (vco_half == $past(vco_half) - 8'h01);
   endproperty
   a_slew: assert property (p_slew) else $error("VCO period jumped");

   property p_band;
      pll_on && vco_half >= band_min && vco_half <= band_max && $stable(vco_band_select) |=>
         vco_half >= band_min && vco_half <= band_max;
   endproperty
   a_band: assert property (p_band) else $error("VCO left its band");

   property p_ref_src;
      ref_tick |-> (act_ref ? (internal_clock_input && !int_q) : (crystal_input && !xtal_q));
   endproperty
   a_ref_src: assert property (p_ref_src) else $error("PLL reference from wrong source");

   property p_ready_pulse;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("APB ready not a single pulse");
endmodule : scg_top
`default_nettype wire

/* File: test/scg_src_model.sv */
// Behavioural model of the four clock sources that feed the generator.
`timescale 1ns/1ps
`default_nettype none
module scg_src_model #(
   parameter int DIRECT_HALF = 2,
   parameter int XTAL_HALF   = 12,
   parameter int INT_HALF    = 40,
   parameter int WAKE_HALF   = 5
) (
   // Clock
   input  wire logic clk,
   // Source levels
   output var  logic direct_clock_input,
   output var  logic crystal_input,
   output var  logic internal_clock_input,
   output var  logic wakeup_clock_input
);
   ////////////////////////////////////////////////////////////////////////////
   // Oscillators run free, so each level changes just after a clk edge and
   // the generator always sees a clean, already synchronised level.
   localparam int HALF [4] = '{DIRECT_HALF, XTAL_HALF, INT_HALF, WAKE_HALF};
   int         cnt [4] = '{0, 0, 0, 0};
   logic [3:0] lvl     = 4'h0;

   always_ff @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (cnt[i] >= HALF[i] - 1) begin
            cnt[i] <= 0;
            lvl[i] <= ~lvl[i];
         end else begin
            cnt[i] <= cnt[i] + 1;
         end
      end
   end

   assign direct_clock_input   = lvl[0];
   assign crystal_input        = lvl[1];
   assign internal_clock_input = lvl[2];
   assign wakeup_clock_input   = lvl[3];
endmodule : scg_src_model
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking testbench of the system clock generator.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import scg_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   localparam int XH = 12;
   localparam int IH = 40;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        direct_clock_input;
   logic        crystal_input;
   logic        internal_clock_input;
   logic        wakeup_clock_input;
   logic        sys_clk;
   int          err_count = 0;
   int          compares = 0;
   int          cycles = 0;
   int          hi_run = 0;
   logic [31:0] rd;
   logic        er;

   scg_top i_scg_top (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .direct_clock_input(direct_clock_input), .crystal_input(crystal_input),
      .internal_clock_input(internal_clock_input), .wakeup_clock_input(wakeup_clock_input),
      .sys_clk(sys_clk));

   scg_src_model #(.DIRECT_HALF(2), .XTAL_HALF(XH), .INT_HALF(IH), .WAKE_HALF(5)) i_scg_src_model (
      .clk(clk), .direct_clock_input(direct_clock_input), .crystal_input(crystal_input),
      .internal_clock_input(internal_clock_input), .wakeup_clock_input(wakeup_clock_input));

   initial begin
      forever #10 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // Called just after a rising edge; holds the request until pready is sampled.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // Polls one status bit until it reaches the wanted value, within a bound.
   task automatic wait_stat(input int idx, input logic val);
      int n;
      n = 0;
      do begin
         apb(1'b0, OFS_CLOCK_STATUS, 32'h0);
         n++;
      end while (rd[idx] !== val && n < 4000);
      check({31'h0, rd[idx]}, {31'h0, val});
   endtask : wait_stat

   // Measures the third full period of sys_clk in clk cycles.
   task automatic meas(input int exp_hi, input int exp_per);
      int hi;
      int lo;
      int n;
      for (int k = 0; k < 2; k++) begin
         hi = 0;
         lo = 0;
         n = 0;
         while (sys_clk !== 1'b0 && n < 30000) begin
            @(posedge clk);
            n++;
         end
         while (sys_clk !== 1'b1 && n < 30000) begin
            @(posedge clk);
            n++;
         end
         while (sys_clk === 1'b1 && hi < 30000) begin
            @(posedge clk);
            hi++;
         end
         while (sys_clk === 1'b0 && lo < 30000) begin
            @(posedge clk);
            lo++;
         end
      end
      check(32'(hi), 32'(exp_hi));
      check(32'(hi + lo), 32'(exp_per));
   endtask : meas

   function automatic logic [31:0] pllw(input logic byp, input logic rf, input logic [1:0] bd,
                                        input logic [3:0] p, input logic [7:0] n, input logic [6:0] k2);
      return {9'h0, k2, n, p, bd, rf, byp};
   endfunction : pllw
   ////////////////////////////////////////////////////////////////////////////
   // A high pulse shorter than two clk cycles is a runt on any configuration here.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles > 95000) begin
         err_count++;
         print_verdict();
      end
      if (rst_b === 1'b1 && sys_clk === 1'b1) begin
         hi_run <= hi_run + 1;
      end else begin
         if (hi_run == 1) begin
            check(32'h1, 32'h0);
         end
         hi_run <= 0;
      end
   end

   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      apb(1'b0, OFS_SYSTEM_CONTROL_REG0, 32'h0);
      check(rd, {30'h0, RST_SOURCE_SELECT});
      apb(1'b0, OFS_PLL_CONTROL_REG0, 32'h0);
      check(rd, pllw(RST_VCO_BYPASS, 1'b0, RST_BAND, RST_PLL_INPUT_DIVIDER_FIELD, RST_PLL_MULTIPLIER_FIELD, RST_PLL_OUTPUT_DIVIDER_FIELD));
      apb(1'b0, OFS_PRESCALE_CONTROL, 32'h0);
      check(rd, {22'h0, RST_PRESCALER_DIVIDER_FIELD});
      apb(1'b0, 12'h010, 32'h0);
      check({31'h0, er}, 32'h1);
      apb(1'b1, OFS_CLOCK_STATUS, 32'hffffffff);
      apb(1'b0, OFS_CLOCK_STATUS, 32'h0);
      check({30'h0, rd[1:0]}, 32'h0);
      meas(5, 10);
      apb(1'b1, OFS_SYSTEM_CONTROL_REG0, {30'h0, SEL_DIRECT});
      wait_stat(3, 1'b0);
      meas(2, 4);
      apb(1'b1, OFS_PRESCALE_CONTROL, 32'h0);
      apb(1'b1, OFS_SYSTEM_CONTROL_REG0, {30'h0, SEL_PLLPRE});
      wait_stat(3, 1'b0);
      meas(XH, 2 * XH);
      apb(1'b1, OFS_PRESCALE_CONTROL, 32'h2);
      meas(2 * XH, 6 * XH);
      apb(1'b1, OFS_PRESCALE_CONTROL, 32'h00010002);
      wait_stat(3, 1'b0);
      meas(2 * IH, 6 * IH);
      apb(1'b1, OFS_PLL_CONTROL_REG0, pllw(1'b0, 1'b0, BAND_LOW, 4'h0, 8'h02, 7'h00));
      wait_stat(4, 1'b1);
      // The lock bit can flash on while the loop still slews, so let a few
      // reference periods pass before the period is measured.
      repeat (240) @(posedge clk);
      meas(XH / 3, 2 * XH / 3);
      apb(1'b1, OFS_PLL_CONTROL_REG0, pllw(1'b0, 1'b1, BAND_HIGH, 4'h1, 8'h0f, 7'h01));
      // The old lock stands until the loop has judged the new ratio.
      wait_stat(4, 1'b0);
      wait_stat(4, 1'b1);
      repeat (480) @(posedge clk);
      meas(IH / 4, IH / 2);
      apb(1'b1, OFS_PLL_CONTROL_REG0, pllw(1'b1, 1'b0, BAND_LOW, 4'h0, 8'h03, 7'h01));
      apb(1'b1, OFS_PRESCALE_CONTROL, 32'h000003ff);
      wait_stat(3, 1'b0);
      meas(512 * 2 * XH, 1024 * 2 * XH);
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
